/* File: dv/cfp_stage_model.sv */
// partner: behavioural power stage and fault comparators
`timescale 1ns/1ps
`default_nettype none
module cfp_stage_model #(
	parameter PERIOD = 32
) (
	// clock and reset
	input wire logic       clk,
	input wire logic       reset,
	// gate requests and injected faults
	input wire logic       high_side_switch_en,
	input wire logic       low_side_switch_en,
	input wire logic       trip_req,
	input wire logic       ovp_req,
	input wire logic       lowbat_req,
	input wire logic       short_req,
	input wire logic [1:0] temp_code,
	// comparator outputs
	output logic           cycle_start,
	output logic           peak_current_limit,
	output logic           battery_overvoltage,
	output logic           battery_low_voltage,
	output logic           temp_above_155c,
	output logic           temp_below_135c,
	output logic           hs_short_cmp,
	output logic           ls_short_cmp,
	output var logic       hs_switch_on,
	output var logic       ls_switch_on
);
	logic [7:0] cyc_cnt_ff;
	// free-running switching cycle and one-cycle gate delay
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cyc_cnt_ff <= 8'h00;
			hs_switch_on <= 1'b0;
			ls_switch_on <= 1'b0;
		end else begin
			cyc_cnt_ff <= (cyc_cnt_ff == PERIOD - 1) ? 8'h00 : cyc_cnt_ff + 8'h01;
			hs_switch_on <= high_side_switch_en;
			ls_switch_on <= low_side_switch_en;
		end
	end
	// comparators only see current while a switch conducts
	assign cycle_start = (cyc_cnt_ff == 8'h00);
	assign peak_current_limit = trip_req && hs_switch_on;
	assign hs_short_cmp = short_req && hs_switch_on;
	assign ls_short_cmp = short_req && ls_switch_on;
	assign battery_overvoltage = ovp_req;
	assign battery_low_voltage = lowbat_req;
	// code 2 hot, 1 in hysteresis band, 0 cool
	assign temp_above_155c = (temp_code == 2'h2);
	assign temp_below_135c = (temp_code == 2'h0);
endmodule
`default_nettype wire

/* File: dv/cfp_sup_assertions.sv */
// checker: protection relations watched at the supervisor ports
`timescale 1ns/1ps
`default_nettype none
module cfp_sup_assertions #(
	parameter OVP_CYCLES = 50
) (
	// clock and reset
	input wire logic       clk,
	input wire logic       reset,
	// comparator flags
	input wire logic       cycle_start,
	input wire logic       peak_current_limit,
	input wire logic       battery_overvoltage,
	input wire logic       battery_low_voltage,
	input wire logic       temp_above_155c,
	input wire logic       temp_below_135c,
	input wire logic       bootstrap_refresh,
	// stage requests
	input wire logic       high_side_switch_en,
	input wire logic       low_side_switch_en,
	input wire logic       battery_sense_node_sink_en,
	input wire logic       internal_gate_regulator_low_limit,
	input wire logic       charger_disabled,
	input wire logic [6:0] charge_current_limit,
	input wire logic [1:0] peak_limit_sel,
	input wire logic [1:0] freq_shift_sel,
	input wire logic [9:0] ls_short_thr_mv
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// ----------------------------------------------------------------
	// helper: consecutive over-voltage cycles, saturating
	// ----------------------------------------------------------------
	logic [19:0] ovp_cnt_ff;
	logic [19:0] nxt_ovp_cnt;
	// margin of two cycles hides the design's own timer latency
	assign nxt_ovp_cnt = !battery_overvoltage ? 20'h0 :
		(&ovp_cnt_ff) ? ovp_cnt_ff : ovp_cnt_ff + 20'h1;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) ovp_cnt_ff <= 20'h0;
		else ovp_cnt_ff <= nxt_ovp_cnt;
	end
	// trip with no new cycle start right after it
	sequence trip_s;
		peak_current_limit ##1 !cycle_start;
	endsequence
	ls_thr_a: assert property (ls_short_thr_mv == 10'h06E)
		else $error("low-side short threshold not 110");
	ocp_cut_a: assert property (peak_current_limit |=> !high_side_switch_en)
		else $error("high side on after peak trip");
	ocp_hold_a: assert property (trip_s |=> !high_side_switch_en)
		else $error("high side back before cycle start");
	ovp_gates_a: assert property (battery_overvoltage |=>
		!high_side_switch_en && !low_side_switch_en)
		else $error("switch on during over-voltage");
	sink_on_a: assert property (battery_overvoltage |=> battery_sense_node_sink_en)
		else $error("sink off during over-voltage");
	sink_off_a: assert property (!battery_overvoltage |=> !battery_sense_node_sink_en)
		else $error("sink on without over-voltage");
	ovp_off_a: assert property (ovp_cnt_ff > OVP_CYCLES + 1 |-> charger_disabled)
		else $error("charger alive after long over-voltage");
	// shutdown flag is registered first, then copied to the outputs: two edges
	thermal_shutdown_a: assert property (temp_above_155c |-> ##2
		internal_gate_regulator_low_limit && !high_side_switch_en)
		else $error("no shutdown when hot");
	// the output trails the cool comparator by two edges
	thermal_shutdown_hold_a: assert property (!temp_below_135c ##1
		internal_gate_regulator_low_limit |=> internal_gate_regulator_low_limit)
		else $error("shutdown left above low threshold");
	lowbat_ls_a: assert property (battery_low_voltage && !bootstrap_refresh
		|=> !low_side_switch_en)
		else $error("low side on during low battery");
	lowbat_cap_a: assert property (battery_low_voltage |=>
		charge_current_limit <= 7'h08)
		else $error("current over cap in low battery");
	sel_code_a: assert property (peak_limit_sel != 2'h3 && freq_shift_sel != 2'h3)
		else $error("illegal selector code");
endmodule
bind cfp_supervisor cfp_sup_assertions #(.OVP_CYCLES(OVP_CYCLES)) chk_i (.*);
`default_nettype wire

/* File: dv/charger_fault_protection_tb_top.sv */
// testbench: register and fault scenarios for the supervisor
`timescale 1ns/1ps
`default_nettype none
module charger_fault_protection_tb_top;
	localparam [34:0] CUR_TAB = {7'h7F, 7'h60, 7'h5F, 7'h30, 7'h2F};
	localparam [9:0]  SEL_TAB = {2'h2, 2'h2, 2'h1, 2'h1, 2'h0};
	reg clk = 1'b0, reset = 1'b1;
	reg [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
	reg [31:0] s_axi_wdata = 32'h0, rd;
	reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	reg trip_req = 0, ovp_req = 0, lowbat_req = 0, short_req = 0, supply_undervoltage_lockout = 0;
	reg adapter_detect_low = 0, bootstrap_refresh = 0;
	reg [1:0] temp_code = 2'h0, rsp;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp, peak_limit_sel, freq_shift_sel, hs_short_thr_sel;
	wire [31:0] s_axi_rdata;
	wire cycle_start, peak_current_limit, battery_overvoltage, battery_low_voltage;
	wire temp_above_155c, temp_below_135c, hs_short_cmp, ls_short_cmp, hs_switch_on, ls_switch_on;
	wire high_side_switch_en, low_side_switch_en, battery_sense_node_sink_en, soft_start_req;
	wire internal_gate_regulator_low_limit, charger_disabled;
	wire [6:0] charge_current_limit;
	wire [9:0] ls_short_thr_mv;
	integer num_errors = 0, checks_done = 0, cyc = 0, i;
	// short timers keep the run brief
	cfp_supervisor #(.OVP_CYCLES(50), .LOWBAT_CYCLES(20), .SS_STEP_TICKS(2)) uut (.*);
	cfp_stage_model #(.PERIOD(32)) stage (.*);
	// clock and hang guard
	always #25 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			num_errors = num_errors + 1;
			final_report;
		end
	end
	task final_report;
		begin
			$display("checks %0d mismatches %0d", checks_done, num_errors);
			if (num_errors == 0 && checks_done > 0) $display("Test passed");
			else $display("Test failed");
			$finish;
		end
	endtask
	task chk(input string nm, input [31:0] seen, input [31:0] exp);
		begin
			checks_done = checks_done + 1;
			if (seen !== exp) begin
				num_errors = num_errors + 1;
				$display("CHECK FAILED %0s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask
	// ready is sampled at the falling edge, stable until the taking edge
	task wr(input [3:0] a, input [31:0] d);
		reg ta, tw, tb;
		begin
			@(posedge clk);
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
			tb = 1'b0;
			while (!tb) begin
				@(negedge clk);
				ta = s_axi_awvalid && s_axi_awready;
				tw = s_axi_wvalid && s_axi_wready;
				tb = s_axi_bvalid;
				rsp = s_axi_bresp;
				@(posedge clk);
				if (ta) s_axi_awvalid <= 1'b0;
				if (tw) s_axi_wvalid <= 1'b0;
			end
			s_axi_bready <= 1'b0;
		end
	endtask
	task rd_reg(input [3:0] a);
		reg ta, tr;
		begin
			@(posedge clk);
			s_axi_araddr <= a;
			{s_axi_arvalid, s_axi_rready} <= 2'h3;
			tr = 1'b0;
			while (!tr) begin
				@(negedge clk);
				ta = s_axi_arvalid && s_axi_arready;
				tr = s_axi_rvalid;
				rd = s_axi_rdata;
				rsp = s_axi_rresp;
				@(posedge clk);
				if (ta) s_axi_arvalid <= 1'b0;
			end
			s_axi_rready <= 1'b0;
		end
	endtask
	task tick(input integer n);
		begin
			repeat (n) @(posedge clk);
			@(negedge clk);
		end
	endtask
	// 0 soft start, 1 high-side enable, else charger disabled
	task wait_on(input integer w, input lvl, input integer lim);
		integer n;
		reg s;
		begin
			n = 0;
			s = ~lvl;
			while (s !== lvl && n < lim) begin
				@(negedge clk);
				case (w)
					0: s = soft_start_req;
					1: s = high_side_switch_en;
					default: s = charger_disabled;
				endcase
				n = n + 1;
			end
			chk("wait", s, lvl);
		end
	endtask
	// main sequence
	initial begin
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		tick(1);
		chk("disabled", charger_disabled, 1);
		chk("ls_thr", ls_short_thr_mv, 10'h06E);
		rd_reg(4'h0);
		chk("opt_rst", rd, 32'h0);
		chk("rresp", rsp, 2'h0);
		for (i = 0; i < 16; i = i + 1) begin
			wr(4'h0, i << 7);
			tick(1);
			chk("hs_thr", hs_short_thr_sel, i[1:0]);
			chk("fshift", freq_shift_sel, i[2] ? (i[3] ? 2 : 1) : 0);
		end
		rd_reg(4'h0);
		chk("opt_rd", rd, 32'h780);
		for (i = 0; i < 5; i = i + 1) begin
			wr(4'h4, CUR_TAB[i*7 +: 7]);
			tick(1);
			chk("peak_sel", peak_limit_sel, SEL_TAB[i*2 +: 2]);
		end
		$display("test options done");
		wr(4'h4, 32'h10);
		chk("bresp", rsp, 2'h0);
		wr(4'hC, 32'h1);
		wait_on(0, 1, 200);
		chk("ss_first", charge_current_limit, 7'h02);
		wait_on(0, 0, 2000);
		chk("ss_end", charge_current_limit, 7'h10);
		wait_on(1, 1, 200);
		@(posedge clk) trip_req <= 1'b1;
		@(posedge clk) trip_req <= 1'b0;
		tick(1);
		chk("hs_trip", high_side_switch_en, 0);
		wait_on(1, 1, 80);
		$display("test soft start and peak limit done");
		@(posedge clk) ovp_req <= 1'b1;
		tick(10);
		chk("sink_on", battery_sense_node_sink_en, 1);
		chk("gates", {high_side_switch_en, low_side_switch_en}, 0);
		@(posedge clk) ovp_req <= 1'b0;
		tick(2);
		chk("sink_off", battery_sense_node_sink_en, 0);
		rd_reg(4'h8);
		chk("ovp_short", rd[5], 0);
		@(posedge clk) ovp_req <= 1'b1;
		tick(60);
		chk("ovp_off", charger_disabled, 1);
		rd_reg(4'h8);
		chk("ovp_latch", rd[5], 1);
		@(posedge clk) ovp_req <= 1'b0;
		wr(4'hC, 32'h3);
		rd_reg(4'h8);
		chk("ovp_clr", rd[5], 0);
		wait_on(0, 0, 2000);
		$display("test over-voltage done");
		@(posedge clk) temp_code <= 2'h2;
		tick(2);
		chk("reg_lim", internal_gate_regulator_low_limit, 1);
		@(posedge clk) temp_code <= 2'h1;
		tick(20);
		chk("hyst", {internal_gate_regulator_low_limit, high_side_switch_en}, 2);
		@(posedge clk) temp_code <= 2'h0;
		wait_on(0, 1, 200);
		wait_on(0, 0, 2000);
		chk("reg_norm", internal_gate_regulator_low_limit, 0);
		$display("test thermal done");
		@(posedge clk) lowbat_req <= 1'b1;
		tick(2);
		rd_reg(4'h8);
		chk("pause", rd[3], 1);
		wait_on(0, 1, 200);
		wait_on(0, 0, 2000);
		chk("cap", charge_current_limit, 7'h08);
		chk("ls_off", low_side_switch_en, 0);
		@(posedge clk) bootstrap_refresh <= 1'b1;
		tick(1);
		chk("refresh", low_side_switch_en, 1);
		@(posedge clk) {bootstrap_refresh, lowbat_req} <= 2'h0;
		tick(1);
		chk("uncap", charge_current_limit, 7'h10);
		$display("test low battery done");
		@(posedge clk) short_req <= 1'b1;
		wait_on(2, 1, 4000);
		@(posedge clk) short_req <= 1'b0;
		rd_reg(4'h8);
		chk("short_lat", {rd[9:7], rd[6]}, 4'hF);
		tick(50);
		chk("still_off", charger_disabled, 1);
		@(posedge clk) supply_undervoltage_lockout <= 1'b1;
		@(posedge clk) supply_undervoltage_lockout <= 1'b0;
		rd_reg(4'h8);
		chk("short_clr", rd[6], 0);
		@(posedge clk) short_req <= 1'b1;
		wait_on(2, 1, 4000);
		@(posedge clk) {short_req, adapter_detect_low} <= 2'h1;
		@(posedge clk) adapter_detect_low <= 1'b0;
		rd_reg(4'h8);
		chk("adp_clr", rd[9:6], 0);
		$display("test short latch done");
		final_report;
	end
endmodule
`default_nettype wire

/* File: verilog/cfp_regs.vh */
// constants for the charger fault protection supervisor
`ifndef CFP_REGS_VH
`define CFP_REGS_VH

// ----------------------------------------------------------------
// axi4-lite register byte offsets
// ----------------------------------------------------------------
`define CFP_OFS_OPTION      4'h0
`define CFP_OFS_CHG_CURRENT 4'h4
`define CFP_OFS_STATUS      4'h8
`define CFP_OFS_CONTROL     4'hC

// ----------------------------------------------------------------
// option register fields
// ----------------------------------------------------------------
`define CFP_OPT_HS_THR_LO  7
`define CFP_OPT_HS_THR_HI  8
`define CFP_OPT_FADJ_EN    9
`define CFP_OPT_FADJ_UP    10
`define CFP_OPT_RESET      32'h0000_0000
`define CFP_CHG_RESET      32'h0000_0000

// ----------------------------------------------------------------
// charge current code, 64 mA per lsb
// ----------------------------------------------------------------
`define CFP_CUR_SS_START   7'h02
`define CFP_CUR_SS_STEP    7'h01
`define CFP_CUR_LOWBAT     7'h08
`define CFP_CUR_THR_9A     7'h30
`define CFP_CUR_THR_12A    7'h60

// ----------------------------------------------------------------
// peak limit, short threshold and frequency shift codes
// ----------------------------------------------------------------
`define CFP_OCP_6A         2'h0
`define CFP_OCP_9A         2'h1
`define CFP_OCP_12A        2'h2
`define CFP_LS_SHORT_MV    10'h06E
`define CFP_FSHIFT_NONE    2'h0
`define CFP_FSHIFT_DOWN    2'h1
`define CFP_FSHIFT_UP      2'h2
`define CFP_SHORT_LIMIT    3'h7

// ----------------------------------------------------------------
// timing, microseconds and clock
// ----------------------------------------------------------------
`define CFP_CLK_MHZ        20
`define CFP_OVP_US         30000
`define CFP_LOWBAT_US      1000
`define CFP_SS_STEP_US     240

`endif

/* File: verilog/cfp_supervisor.v */
// charger fault protection supervisor with axi4-lite registers
`include "cfp_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module cfp_supervisor #(
	parameter BLANK_CYCLES = 8,
	parameter TICK_CYCLES  = 20,
	parameter OVP_CYCLES   = `CFP_OVP_US * `CFP_CLK_MHZ,
	parameter LOWBAT_CYCLES = `CFP_LOWBAT_US * `CFP_CLK_MHZ,
	parameter SS_STEP_TICKS = `CFP_SS_STEP_US * `CFP_CLK_MHZ / TICK_CYCLES
) (
	// clock and reset
	input  wire        clk,
	input  wire        reset,
	// axi4-lite write address
	input  wire [3:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	// axi4-lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	// axi4-lite write response
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// axi4-lite read address
	input  wire [3:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	// axi4-lite read data
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// analog comparator flags
	input  wire        cycle_start,
	input  wire        peak_current_limit,
	input  wire        battery_overvoltage,
	input  wire        battery_low_voltage,
	input  wire        temp_above_155c,
	input  wire        temp_below_135c,
	input  wire        hs_short_cmp,
	input  wire        ls_short_cmp,
	input  wire        hs_switch_on,
	input  wire        ls_switch_on,
	input  wire        bootstrap_refresh,
	input  wire        supply_undervoltage_lockout,
	input  wire        adapter_detect_low,
	// power stage requests
	output reg         high_side_switch_en,
	output reg         low_side_switch_en,
	output reg         battery_sense_node_sink_en,
	output reg         soft_start_req,
	output reg  [6:0]  charge_current_limit,
	output reg  [1:0]  peak_limit_sel,
	output reg  [1:0]  freq_shift_sel,
	output reg  [1:0]  hs_short_thr_sel,
	output reg  [9:0]  ls_short_thr_mv,
	output reg         internal_gate_regulator_low_limit,
	output reg         charger_disabled
);

	// ----------------------------------------------------------------
	// register bus
	// ----------------------------------------------------------------
	reg [31:0] option_config_register_ff;
	reg [6:0]  chg_current_ff;
	reg        charge_en_ff;
	reg        aw_full_ff;
	reg [3:0]  aw_addr_ff;
	reg        w_full_ff;
	reg [31:0] w_data_ff;
	reg [3:0]  w_strb_ff;
	reg        ovp_latch_ff;
	reg        short_latch_ff;
	reg        thermal_shutdown_ff;
	reg        lowbat_hold_ff;
	reg [2:0]  short_cnt_ff;
	reg        status_clr;
	integer    i;

	// single outstanding write: channels accepted independently
	assign s_axi_awready = !aw_full_ff && !s_axi_bvalid;
	assign s_axi_wready  = !w_full_ff && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	// write channel capture and response
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			aw_full_ff <= 1'b0;
			aw_addr_ff <= 4'h0;
			w_full_ff <= 1'b0;
			w_data_ff <= 32'h0000_0000;
			w_strb_ff <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			option_config_register_ff <= `CFP_OPT_RESET;
			chg_current_ff <= 7'h00;
			charge_en_ff <= 1'b0;
			status_clr <= 1'b0;
		end else begin
			status_clr <= 1'b0;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_ff <= 1'b1;
				aw_addr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_ff <= 1'b1;
				w_data_ff <= s_axi_wdata;
				w_strb_ff <= s_axi_wstrb;
			end
			if (aw_full_ff && w_full_ff) begin
				aw_full_ff <= 1'b0;
				w_full_ff <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= 2'h0;
				case (aw_addr_ff)
					`CFP_OFS_OPTION: begin
						for (i = 0; i < 4; i = i + 1)
							if (w_strb_ff[i])
								option_config_register_ff[i*8 +: 8] <= w_data_ff[i*8 +: 8];
					end
					`CFP_OFS_CHG_CURRENT: begin
						if (w_strb_ff[0])
							chg_current_ff <= w_data_ff[6:0];
					end
					`CFP_OFS_CONTROL: begin
						if (w_strb_ff[0]) begin
							charge_en_ff <= w_data_ff[0];
							status_clr <= w_data_ff[1];
						end
					end
					`CFP_OFS_STATUS: s_axi_bresp <= 2'h0;
					default: s_axi_bresp <= 2'h2; // slverr on unmapped
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// read channel, one cycle after the address
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'h0;
			case (s_axi_araddr)
				`CFP_OFS_OPTION: s_axi_rdata <= option_config_register_ff;
				`CFP_OFS_CHG_CURRENT: s_axi_rdata <= {25'h0, chg_current_ff};
				`CFP_OFS_STATUS: s_axi_rdata <= {22'h0, short_cnt_ff, short_latch_ff,
					ovp_latch_ff, thermal_shutdown_ff, lowbat_hold_ff, battery_overvoltage,
					soft_start_req, charger_disabled};
				`CFP_OFS_CONTROL: s_axi_rdata <= {31'h0, charge_en_ff};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= 2'h2;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// timers
	// ----------------------------------------------------------------
	reg        ocp_trip_ff;
	reg        lowbat_seen_ff;
	reg [1:0]  ss_state_ff;
	reg [6:0]  ss_level_ff;
	reg [15:0] tick_cnt_ff;
	reg [15:0] ss_tick_ff;
	reg [7:0]  hs_blank_ff;
	reg [7:0]  ls_blank_ff;
	reg        hs_on_d_ff;
	reg        ls_on_d_ff;
	wire       ovp_done;
	wire       lowbat_done;
	wire       tick;
	wire       charge_ok;

	localparam SS_IDLE = 2'h0;
	localparam SS_RAMP = 2'h1;
	localparam SS_RUN  = 2'h2;

	// persistence of over-voltage, reset whenever the condition drops
	cfp_timer #(.CW(20)) u_ovp_timer (
		.clk   (clk),
		.reset (reset),
		.run   (battery_overvoltage),
		.limit (OVP_CYCLES[19:0]),
		.done  (ovp_done)
	);

	// fixed pause after a low-battery detection
	cfp_timer #(.CW(20)) u_lowbat_timer (
		.clk   (clk),
		.reset (reset),
		.run   (lowbat_hold_ff),
		.limit (LOWBAT_CYCLES[19:0]),
		.done  (lowbat_done)
	);

	// tick prescaler for soft-start steps
	assign tick = (tick_cnt_ff == TICK_CYCLES[15:0] - 16'h0001);

	// ----------------------------------------------------------------
	// protection state
	// ----------------------------------------------------------------
	assign charge_ok = charge_en_ff && !ovp_latch_ff && !short_latch_ff && !thermal_shutdown_ff
	                   && !lowbat_hold_ff;

	// short events counted while blanking is zero; the turn-on cycle itself is counted before blanking loads
	wire hs_short_ev = hs_switch_on && hs_blank_ff == 8'h00 && hs_short_cmp;
	wire ls_short_ev = ls_switch_on && ls_blank_ff == 8'h00 && ls_short_cmp;

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			ocp_trip_ff <= 1'b0;
			thermal_shutdown_ff <= 1'b0;
			lowbat_hold_ff <= 1'b0;
			lowbat_seen_ff <= 1'b0;
			ovp_latch_ff <= 1'b0;
			short_latch_ff <= 1'b0;
			short_cnt_ff <= 3'h0;
			hs_blank_ff <= 8'h00;
			ls_blank_ff <= 8'h00;
			hs_on_d_ff <= 1'b0;
			ls_on_d_ff <= 1'b0;
			tick_cnt_ff <= 16'h0000;
		end else begin
			tick_cnt_ff <= tick ? 16'h0000 : tick_cnt_ff + 16'h0001;
			// trip holds to the cycle end; a new trip wins over cycle start
			if (peak_current_limit)
				ocp_trip_ff <= 1'b1;
			else if (cycle_start)
				ocp_trip_ff <= 1'b0;
			// hysteresis between the two temperature comparators
			if (temp_above_155c)
				thermal_shutdown_ff <= 1'b1;
			else if (temp_below_135c)
				thermal_shutdown_ff <= 1'b0;
			// a new low-battery edge starts one pause
			lowbat_seen_ff <= battery_low_voltage;
			if (battery_low_voltage && !lowbat_seen_ff)
				lowbat_hold_ff <= 1'b1;
			else if (lowbat_done)
				lowbat_hold_ff <= 1'b0;
			// sticky disable; set wins over software clear
			if (ovp_done)
				ovp_latch_ff <= 1'b1;
			else if (status_clr && !battery_overvoltage)
				ovp_latch_ff <= 1'b0;
			// blanking restarts on each switch turn-on edge
			hs_on_d_ff <= hs_switch_on;
			ls_on_d_ff <= ls_switch_on;
			if (hs_switch_on && !hs_on_d_ff)
				hs_blank_ff <= BLANK_CYCLES[7:0];
			else if (hs_blank_ff != 8'h00)
				hs_blank_ff <= hs_blank_ff - 8'h01;
			if (ls_switch_on && !ls_on_d_ff)
				ls_blank_ff <= BLANK_CYCLES[7:0];
			else if (ls_blank_ff != 8'h00)
				ls_blank_ff <= ls_blank_ff - 8'h01;
			// counter and latch clear only on undervoltage or adapter removal
			if (supply_undervoltage_lockout || adapter_detect_low) begin
				short_cnt_ff <= 3'h0;
				short_latch_ff <= 1'b0;
			end else if ((hs_short_ev || ls_short_ev) && !short_latch_ff) begin
				short_cnt_ff <= short_cnt_ff + 3'h1;
				if (short_cnt_ff == `CFP_SHORT_LIMIT - 3'h1)
					short_latch_ff <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// soft start ramp
	// ----------------------------------------------------------------
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			ss_state_ff <= SS_IDLE;
			ss_level_ff <= 7'h00;
			ss_tick_ff <= 16'h0000;
		end else begin
			case (ss_state_ff)
				SS_IDLE: begin
					ss_tick_ff <= 16'h0000;
					ss_level_ff <= `CFP_CUR_SS_START;
					if (charge_ok)
						ss_state_ff <= SS_RAMP;
				end
				SS_RAMP: begin
					if (!charge_ok)
						ss_state_ff <= SS_IDLE;
					else if (ss_level_ff >= chg_current_ff)
						ss_state_ff <= SS_RUN;
					else if (tick) begin
						if (ss_tick_ff >= SS_STEP_TICKS[15:0] - 16'h0001) begin
							ss_tick_ff <= 16'h0000;
							ss_level_ff <= ss_level_ff + `CFP_CUR_SS_STEP;
						end else begin
							ss_tick_ff <= ss_tick_ff + 16'h0001;
						end
					end
				end
				SS_RUN: begin
					ss_level_ff <= chg_current_ff;
					if (!charge_ok)
						ss_state_ff <= SS_IDLE;
				end
				default: ss_state_ff <= SS_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// output requests
	// ----------------------------------------------------------------
	reg [6:0] cur_lim;

	always @* begin
		cur_lim = (ss_level_ff < chg_current_ff) ? ss_level_ff : chg_current_ff;
		if (battery_low_voltage && cur_lim > `CFP_CUR_LOWBAT)
			cur_lim = `CFP_CUR_LOWBAT;
	end

	// registered outputs, all gates low when not charging
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			high_side_switch_en <= 1'b0;
			low_side_switch_en <= 1'b0;
			battery_sense_node_sink_en <= 1'b0;
			soft_start_req <= 1'b0;
			charge_current_limit <= 7'h00;
			peak_limit_sel <= `CFP_OCP_6A;
			freq_shift_sel <= `CFP_FSHIFT_NONE;
			hs_short_thr_sel <= 2'h0;
			ls_short_thr_mv <= `CFP_LS_SHORT_MV;
			internal_gate_regulator_low_limit <= 1'b0;
			charger_disabled <= 1'b1;
		end else begin
			high_side_switch_en <= charge_ok && ss_state_ff != SS_IDLE
				&& !battery_overvoltage
				&& !ocp_trip_ff && !peak_current_limit;
			low_side_switch_en <= charge_ok && ss_state_ff != SS_IDLE
				&& !battery_overvoltage
				&& (!battery_low_voltage || bootstrap_refresh);
			battery_sense_node_sink_en <= battery_overvoltage;
			soft_start_req <= ss_state_ff == SS_RAMP;
			charge_current_limit <= cur_lim;
			if (chg_current_ff >= `CFP_CUR_THR_12A)
				peak_limit_sel <= `CFP_OCP_12A;
			else if (chg_current_ff >= `CFP_CUR_THR_9A)
				peak_limit_sel <= `CFP_OCP_9A;
			else
				peak_limit_sel <= `CFP_OCP_6A;
			if (!option_config_register_ff[`CFP_OPT_FADJ_EN])
				freq_shift_sel <= `CFP_FSHIFT_NONE;
			else if (option_config_register_ff[`CFP_OPT_FADJ_UP])
				freq_shift_sel <= `CFP_FSHIFT_UP;
			else
				freq_shift_sel <= `CFP_FSHIFT_DOWN;
			hs_short_thr_sel <= option_config_register_ff[`CFP_OPT_HS_THR_HI:`CFP_OPT_HS_THR_LO];
			ls_short_thr_mv <= `CFP_LS_SHORT_MV;
			internal_gate_regulator_low_limit <= thermal_shutdown_ff;
			charger_disabled <= !charge_ok || ss_state_ff == SS_IDLE;
		end
	end

endmodule
`default_nettype wire

/* File: verilog/cfp_timer.v */
// one-shot / persistence timer counting clock cycles
`timescale 1ns/1ps
`default_nettype none

module cfp_timer #(
	parameter CW = 20
) (
	// clock and reset
	input  wire          clk,
	input  wire          reset,
	// control
	input  wire          run,
	input  wire [CW-1:0] limit,
	// status
	output wire          done
);

	reg [CW-1:0] count_ff;
	wire [CW-1:0] nxt_count;

	// counts while run, clears when run drops; saturates at the limit
	assign nxt_count = !run ? {CW{1'b0}} :
	                   (count_ff >= limit) ? count_ff : count_ff + {{(CW-1){1'b0}}, 1'b1};
	assign done = run && (count_ff >= limit);

	// ----------------------------------------------------------------
	// counter
	// ----------------------------------------------------------------
	always @(posedge clk or posedge reset) begin
		if (reset)
			count_ff <= {CW{1'b0}};
		else
			count_ff <= nxt_count;
	end

endmodule
`default_nettype wire
